// >>> bench/ice_evac_properties.sv
module ice_evac_properties #(
  parameter int NUM_BACKUP = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic incumbent_detect,
  input wire logic data_allow,
  input wire logic tx_allow,
  input wire logic elem_valid,
  input wire ice_pkg::ice_elem_t tx_elem,
  input wire logic tune_req,
  input wire logic join_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ****************
  // Bus answer
  // ****************
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  property p_answer;
    s_access |=> s_answer;
  endproperty
  a_answer: assert property (p_answer) else $error("pready late or held");
  property p_no_err;
    pslverr == 1'b0;
  endproperty
  a_no_err: assert property (p_no_err) else $error("pslverr raised");
  // ****************
  // Evacuation
  // ****************
  property p_stop_data;
    incumbent_detect && data_allow |=> !data_allow;
  endproperty
  a_stop_data: assert property (p_stop_data) else $error("data kept after detect");
  property p_quiet_elem;
    elem_valid |-> !data_allow;
  endproperty
  a_quiet_elem: assert property (p_quiet_elem) else $error("data during announce");
  property p_dead_air;
    !tx_allow |-> !elem_valid;
  endproperty
  a_dead_air: assert property (p_dead_air) else $error("element after cutoff");
  property p_no_copy;
    elem_valid && tx_elem.target_channel == 8'hff |-> !tx_elem.copy_flag;
  endproperty
  a_no_copy: assert property (p_no_copy) else $error("copy flag with no channel");
  property p_vacate_first;
    $rose(tune_req) |-> !tx_allow;
  endproperty
  a_vacate_first: assert property (p_vacate_first) else $error("retune while on air");
  property p_tune_pulse;
    tune_req |=> !tune_req;
  endproperty
  a_tune_pulse: assert property (p_tune_pulse) else $error("tune_req held");
  property p_join_pulse;
    join_req |=> !join_req [*2];
  endproperty
  a_join_pulse: assert property (p_join_pulse) else $error("join_req held");
endmodule

// >>> bench/ice_evac_tb.sv
`include "ice_map.svh"
module ice_evac_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, incumbent_detect, signalling_lost;
  logic beacon_slot, rx_elem_valid, rx_same_group, scan_found, data_allow, tx_allow, elem_valid;
  logic tune_req, reuse_resv, join_req, scan_active, irq, send, tx_on;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, b;
  logic [7:0] tune_chan, ch;
  ice_pkg::ice_elem_t rx_elem, tx_elem;
  int mismatches = 0;
  int n_compared = 0;
  logic [11:0] ad [5] = '{`ICE_OFF_AIRTIME, `ICE_OFF_EVACTIME, `ICE_OFF_SFLEN, `ICE_OFF_CTRL, 12'h100};
  logic [31:0] ev [5] = '{`ICE_RST_AIRTIME, `ICE_RST_EVACTIME, `ICE_RST_SFLEN, 32'h400, 32'h0};

  ice_evac dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .incumbent_detect(incumbent_detect),
    .signalling_lost(signalling_lost), .tx_active(tx_on), .beacon_slot(beacon_slot), .rx_elem_valid(rx_elem_valid),
    .rx_elem(rx_elem), .rx_same_group(rx_same_group), .scan_found(scan_found), .data_allow(data_allow),
    .tx_allow(tx_allow), .elem_valid(elem_valid), .tx_elem(tx_elem), .tune_req(tune_req), .tune_chan(tune_chan),
    .reuse_resv(reuse_resv), .join_req(join_req), .scan_active(scan_active), .irq(irq));
  ice_peer_model peer (.clk(clk), .send(send), .chan(ch), .scan_active(scan_active), .beacon_slot(beacon_slot),
    .rx_elem_valid(rx_elem_valid), .rx_elem(rx_elem), .rx_same_group(rx_same_group), .scan_found(scan_found));

  // ****************
  // Helpers
  // ****************
  task automatic chk_reg(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk_bit(input logic e, input logic g);
    chk_reg({31'h0, e}, {31'h0, g});
  endtask
  // Request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
    end
    q = prdata;
    {psel, penable} <= 2'b00;
  endtask
  // Bounded wait on one output: 0 elem, 1 tune, 2 join, 3 scan
  task automatic wait_on(input int k, input int lim);
    int n;
    logic [3:0] v;
    n = 0;
    v = {scan_active, join_req, tune_req, elem_valid};
    while (v[k] !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
      v = {scan_active, join_req, tune_req, elem_valid};
    end
    chk_bit(1'b1, v[k]);
  endtask
  task automatic do_reset;
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // Short evacuation limit keeps each run brief
  task automatic start(input logic [31:0] c, input logic [31:0] bk, input logic d);
    do_reset();
    apb(1'b1, `ICE_OFF_CTRL, c, r);
    apb(1'b1, `ICE_OFF_BACKUP, bk, r);
    apb(1'b1, `ICE_OFF_EVACTIME, 32'h28, r);
    apb(1'b1, `ICE_OFF_MASK, 32'h1, r);
    @(posedge clk);
    incumbent_detect <= d;
    @(posedge clk);
    incumbent_detect <= 1'b0;
    @(negedge clk);
    chk_bit(~d, data_allow);
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
  // ****************
  // Tests
  // ****************
  initial begin
    {rstn, psel, penable, pwrite, incumbent_detect, signalling_lost, send, tx_on} = 8'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    ch = 8'h0;
    void'($urandom(32'h43c76c1d));
    do_reset();
    chk_bit(1'b1, tx_allow & data_allow);
    apb(1'b1, 12'h100, $urandom, r);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ad[i], 32'h0, r);
      chk_reg(ev[i], r);
    end
    $display("registers done");
    // Master with a ranked backup and copy allowed
    ch = 8'($urandom_range(0, 254));
    b = $urandom;
    start(32'h405, {b[31:8], ch}, 1'b1);
    wait_on(0, 20);
    chk_reg({24'h0, ch}, {24'h0, tx_elem.target_channel});
    chk_bit(1'b1, tx_elem.copy_flag);
    chk_bit(1'b1, tx_elem.countdown <= 32'h28);
    chk_bit(1'b1, irq);
    wait_on(1, 45);
    chk_reg({24'h0, ch}, {24'h0, tune_chan});
    chk_bit(1'b0, tx_allow);
    @(negedge clk);
    chk_bit(1'b1, reuse_resv);
    apb(1'b0, `ICE_OFF_STATUS, 32'h0, r);
    chk_reg(32'h3, r & 32'h3);
    @(negedge clk);
    chk_bit(1'b0, irq);
    apb(1'b0, `ICE_OFF_STATUS, 32'h0, r);
    chk_reg(32'h0, r & 32'h3);
    $display("master evacuation done");
    // Peer owner with no backup left
    start(32'h402, 32'hffffffff, 1'b1);
    wait_on(0, 20);
    chk_reg(32'hff, {24'h0, tx_elem.target_channel});
    wait_on(3, 45);
    apb(1'b0, `ICE_OFF_STATUS, 32'h0, r);
    chk_reg(32'h4, r & 32'h4);
    $display("scan fallback done");
    // Plain member follows a same-group element
    ch = 8'($urandom_range(0, 254));
    start(32'h400, 32'hffffffff, 1'b0);
    apb(1'b1, `ICE_OFF_AIRTIME, 32'h5, r);
    tx_on <= 1'b1;
    @(posedge clk);
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    wait_on(1, 40);
    chk_reg({24'h0, ch}, {24'h0, tune_chan});
    wait_on(2, 5);
    tx_on <= 1'b0;
    @(negedge clk);
    chk_bit(1'b1, tx_allow);
    apb(1'b0, `ICE_OFF_STATUS, 32'h0, r);
    chk_reg(32'h8, r & 32'h8);
    $display("member follow done");
    // Signalling lost: autonomous move
    ch = 8'($urandom_range(0, 254));
    signalling_lost <= 1'b1;
    start(32'h401, {24'hffffff, ch}, 1'b1);
    wait_on(1, 45);
    chk_reg({24'h0, ch}, {24'h0, tune_chan});
    signalling_lost <= 1'b0;
    $display("autonomous move done");
    end_sim();
  end
endmodule

bind ice_evac ice_evac_properties #(.NUM_BACKUP(NUM_BACKUP)) u_props (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .incumbent_detect(incumbent_detect),
  .data_allow(data_allow), .tx_allow(tx_allow), .elem_valid(elem_valid), .tx_elem(tx_elem),
  .tune_req(tune_req), .join_req(join_req));

// >>> bench/ice_peer_model.sv
module ice_peer_model (
  input wire logic clk,
  input wire logic send,
  input wire logic [7:0] chan,
  input wire logic scan_active,
  output logic beacon_slot,
  output logic rx_elem_valid,
  output ice_pkg::ice_elem_t rx_elem,
  output logic rx_same_group,
  output logic scan_found
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] tick = 4'h0;
  logic [4:0] dwell = 5'h0;
  initial begin
    {beacon_slot, rx_elem_valid, rx_same_group, scan_found} = 4'h0;
    rx_elem = '0;
  end
  // Group peer: beacons, element sends, found channel while scanning
  always @(posedge clk) begin
    tick <= tick + 4'h1;
    beacon_slot <= (tick == 4'h7) || (tick == 4'hf);
    rx_elem_valid <= send;
    rx_same_group <= send ? 1'b1 : ~rx_same_group;
    if (send) begin
      rx_elem <= '{target_channel: chan, copy_flag: 1'b0, countdown: 32'h1e};
    end else begin
      rx_elem <= ~rx_elem; // Stale data must not look valid
    end
    dwell <= scan_active ? dwell + 5'h1 : 5'h0;
    scan_found <= (dwell == 5'h14);
  end
endmodule

// >>> logic/ice_evac.sv
// The implementer's own choices: the register addresses and register access over APB.
`include "ice_map.svh"
// **************************************************************
// **************************************************************
module ice_evac #(
  parameter int NUM_BACKUP = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic incumbent_detect,
  input wire logic signalling_lost,
  input wire logic tx_active,
  input wire logic beacon_slot,
  input wire logic rx_elem_valid,
  input wire ice_pkg::ice_elem_t rx_elem,
  input wire logic rx_same_group,
  input wire logic scan_found,
  output logic data_allow,
  output logic tx_allow,
  output logic elem_valid,
  output ice_pkg::ice_elem_t tx_elem,
  output logic tune_req,
  output logic [7:0] tune_chan,
  output logic reuse_resv,
  output logic join_req,
  output logic scan_active,
  output logic irq
);

  // **************************************************************
  // State
  // **************************************************************
  typedef struct packed {
    ice_pkg::ice_state_t state;
    logic [2:0] ctrl;
    logic [7:0] repeat_cfg;
    logic [`ICE_NUM_EV-1:0] status;
    logic [`ICE_NUM_EV-1:0] mask;
    logic [NUM_BACKUP-1:0][7:0] backup;
    logic [31:0] airtime_lim;
    logic [31:0] evac_lim;
    logic [31:0] sf_len;
    logic [31:0] countdown;
    logic [31:0] evac_timer;
    logic [31:0] airtime_used;
    logic [31:0] dwell;
    logic [7:0] repeats;
    logic [7:0] scan_chan;
    ice_pkg::ice_elem_t elem;
    logic elem_valid;
    logic tx_allow;
    logic data_allow;
    logic [7:0] tune_chan;
    logic tune_req;
    logic reuse_resv;
    logic join_req;
    logic irq;
    logic pready;
    logic [31:0] prdata;
  } ice_st_t;

  logic [1:0] rst_sync_reg;
  logic rst_n_int;
  ice_st_t st_reg;
  ice_st_t st_next;

  // Release reset through two flops so deassertion is clean
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n_int = rst_sync_reg[1];

  // Highest-priority valid backup: index 0 ranks first
  function automatic logic [7:0] best_backup(input logic [NUM_BACKUP-1:0][7:0] list);
    logic [7:0] pick;
    pick = `ICE_NO_CHANNEL;
    for (int i = NUM_BACKUP - 1; i >= 0; i--) begin
      if (list[i] != `ICE_NO_CHANNEL) begin
        pick = list[i];
      end
    end
    return pick;
  endfunction

  // Saturating decrement, shared by the countdown and evacuation timers
  function automatic logic [31:0] dec_sat(input logic [31:0] v);
    return (v == 32'h0) ? 32'h0 : v - 32'h1;
  endfunction

  logic coordinator;
  logic apb_wr;
  logic apb_rd;
  logic [`ICE_NUM_EV-1:0] ev;
  logic [7:0] chosen;
  assign coordinator = st_reg.ctrl[`ICE_CTRL_MASTER] | st_reg.ctrl[`ICE_CTRL_OWNER];
  // Bus decode
  // A write lands on the edge that also sees ready high,
  // so the master and the register agree on the commit edge.
  assign apb_wr = psel & penable & pwrite & st_reg.pready;
  // Read data is prepared one edge early so it stands with ready
  assign apb_rd = psel & penable & ~pwrite & ~st_reg.pready;
  assign chosen = best_backup(st_reg.backup);

  // **************************************************************
  // Next state
  // **************************************************************
  always_comb begin
    st_next = st_reg;
    ev = '0;
    st_next.tune_req = 1'b0;
    st_next.join_req = 1'b0;
    st_next.pready = 1'b0;
    // Timers run every cycle while evacuating
    st_next.countdown = dec_sat(st_reg.countdown);
    st_next.evac_timer = dec_sat(st_reg.evac_timer);
    if (!st_reg.data_allow && tx_active) begin
      st_next.airtime_used = st_reg.airtime_used + 32'h1;
    end
    case (st_reg.state)
      ice_pkg::ICE_IDLE: begin
        st_next.airtime_used = 32'h0;
        if (incumbent_detect) begin
          ev[`ICE_EV_DETECT] = 1'b1;
          st_next.data_allow = 1'b0;
          st_next.evac_timer = st_reg.evac_lim;
          st_next.countdown = st_reg.evac_lim;
          if (coordinator) begin
            st_next.elem.target_channel = chosen;
            st_next.elem.copy_flag = (chosen != `ICE_NO_CHANNEL) & st_reg.ctrl[`ICE_CTRL_COPY];
            st_next.elem.countdown = st_reg.evac_lim;
            st_next.repeats = st_reg.repeat_cfg;
            st_next.elem_valid = 1'b1;
            st_next.state = ice_pkg::ICE_ANNOUNCE;
          end else begin
            st_next.elem.target_channel = chosen;
            st_next.elem.copy_flag = 1'b0;
            st_next.state = ice_pkg::ICE_COUNT;
          end
        end else if (rx_elem_valid && rx_same_group) begin
          // Adopt announced move from our own group only
          st_next.data_allow = 1'b0;
          st_next.elem = rx_elem;
          st_next.countdown = rx_elem.countdown;
          st_next.evac_timer = st_reg.evac_lim;
          st_next.state = ice_pkg::ICE_COUNT;
        end
      end
      ice_pkg::ICE_ANNOUNCE: begin
        // Keep element live; update countdown every cycle
        st_next.elem.countdown = st_reg.countdown;
        if (beacon_slot) begin
          st_next.repeats = st_reg.repeats - 8'h1;
          if (st_reg.repeats <= 8'h1) begin
            st_next.elem_valid = 1'b0;
            st_next.state = ice_pkg::ICE_COUNT;
          end
        end
        if (st_reg.countdown == 32'h0 || st_reg.evac_timer == 32'h0) begin
          st_next.elem_valid = 1'b0;
          st_next.state = ice_pkg::ICE_COUNT;
        end
      end
      ice_pkg::ICE_COUNT: begin
        if (signalling_lost && st_reg.elem.target_channel != `ICE_NO_CHANNEL) begin
          st_next.state = ice_pkg::ICE_AUTO;
        end else if (st_reg.countdown == 32'h0 || st_reg.evac_timer == 32'h0) begin
          st_next.tx_allow = 1'b0;
          ev[`ICE_EV_VACATED] = 1'b1;
          if (st_reg.elem.target_channel == `ICE_NO_CHANNEL) begin
            st_next.scan_chan = 8'h0;
            st_next.dwell = {st_reg.sf_len[30:0], 1'b0};
            ev[`ICE_EV_SCAN] = 1'b1;
            st_next.state = ice_pkg::ICE_SCAN;
          end else begin
            st_next.tune_chan = st_reg.elem.target_channel;
            st_next.tune_req = 1'b1;
            st_next.state = st_reg.elem.copy_flag ? ice_pkg::ICE_RESUME : ice_pkg::ICE_JOIN;
          end
        end
      end
      // Beacons are gone, so nobody can be told about the move;
      // only a backup agreed beforehand can be used here.
      ice_pkg::ICE_AUTO: begin
        // No signalling possible: move straight to pre-agreed backup
        st_next.tx_allow = 1'b0;
        st_next.tune_chan = st_reg.elem.target_channel;
        st_next.tune_req = 1'b1;
        ev[`ICE_EV_VACATED] = 1'b1;
        st_next.state = ice_pkg::ICE_JOIN;
      end
      // Fallback scan; channel codes wrap after the last one,
      // software must stop a scan that finds nothing.
      ice_pkg::ICE_SCAN: begin
        if (scan_found) begin
          st_next.state = ice_pkg::ICE_JOIN;
        end else if (st_reg.dwell == 32'h0) begin
          st_next.scan_chan = st_reg.scan_chan + 8'h1;
          st_next.tune_chan = st_reg.scan_chan + 8'h1;
          st_next.tune_req = 1'b1;
          st_next.dwell = {st_reg.sf_len[30:0], 1'b0};
        end else begin
          st_next.dwell = st_reg.dwell - 32'h1;
        end
      end
      // Arrival without copied reservations: ask for a group join
      ice_pkg::ICE_JOIN: begin
        st_next.join_req = 1'b1;
        st_next.reuse_resv = 1'b0;
        ev[`ICE_EV_JOIN] = 1'b1;
        st_next.tx_allow = 1'b1;
        st_next.data_allow = 1'b1;
        st_next.state = ice_pkg::ICE_IDLE;
      end
      // Arrival on an empty backup: old reservations carry over
      ice_pkg::ICE_RESUME: begin
        st_next.reuse_resv = 1'b1;
        st_next.tx_allow = 1'b1;
        st_next.data_allow = 1'b1;
        st_next.state = ice_pkg::ICE_IDLE;
      end
      default: begin
        st_next.state = ice_pkg::ICE_IDLE;
      end
    endcase
    // Airtime cap: block transmit once the budget is spent
    // Judged on the next data state, so arrival on the new channel
    // lifts the cap instead of leaving transmit blocked for good.
    if (!st_next.data_allow && st_reg.airtime_used >= st_reg.airtime_lim) begin
      st_next.tx_allow = 1'b0;
      ev[`ICE_EV_AIRTIME] = st_reg.tx_allow;
    end
    // Register writes, one-cycle ready
    if (apb_wr) begin
      case (paddr)
        `ICE_OFF_CTRL: begin
          st_next.ctrl = pwdata[2:0];
          st_next.repeat_cfg = pwdata[`ICE_CTRL_REPEAT_LSB +: 8];
        end
        `ICE_OFF_MASK: st_next.mask = pwdata[`ICE_NUM_EV-1:0];
        `ICE_OFF_BACKUP: begin
          for (int i = 0; i < NUM_BACKUP && i < 4; i++) begin
            st_next.backup[i] = pwdata[8*i +: 8];
          end
        end
        `ICE_OFF_AIRTIME: st_next.airtime_lim = pwdata;
        `ICE_OFF_EVACTIME: st_next.evac_lim = pwdata;
        `ICE_OFF_SFLEN: st_next.sf_len = pwdata;
        default: begin
        end
      endcase
    end
    st_next.prdata = 32'h0;
    if (apb_rd) begin
      case (paddr)
        `ICE_OFF_CTRL: st_next.prdata = {16'h0, st_reg.repeat_cfg, 5'h0, st_reg.ctrl};
        `ICE_OFF_STATUS: st_next.prdata = {27'h0, st_reg.status};
        `ICE_OFF_MASK: st_next.prdata = {27'h0, st_reg.mask};
        `ICE_OFF_STATE: st_next.prdata = {17'h0, st_reg.scan_chan, st_reg.state};
        `ICE_OFF_BACKUP: st_next.prdata = 32'(st_reg.backup);
        `ICE_OFF_COUNTDOWN: st_next.prdata = st_reg.countdown;
        `ICE_OFF_AIRTIME: st_next.prdata = st_reg.airtime_lim;
        `ICE_OFF_EVACTIME: st_next.prdata = st_reg.evac_lim;
        `ICE_OFF_SFLEN: st_next.prdata = st_reg.sf_len;
        `ICE_OFF_ELEM: st_next.prdata = {23'h0, st_reg.elem.copy_flag, st_reg.elem.target_channel};
        default: st_next.prdata = 32'h0;
      endcase
    end
    if (psel && penable && !st_reg.pready) begin
      st_next.pready = 1'b1;
    end
    // Sticky events; read clears, a new event wins over the clear
    if (apb_rd && paddr == `ICE_OFF_STATUS) begin
      st_next.status = ev;
    end else begin
      st_next.status = st_reg.status | ev;
    end
    st_next.irq = |(st_next.status & st_reg.mask);
  end

  // Single state register
  // Reset values come from constants only; the backup list
  // starts empty so, until software fills it, a detection leads to the fallback scan.
  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      st_reg <= '0;
      st_reg.state <= ice_pkg::ICE_IDLE;
      st_reg.backup <= {NUM_BACKUP{`ICE_NO_CHANNEL}};
      st_reg.airtime_lim <= `ICE_RST_AIRTIME;
      st_reg.evac_lim <= `ICE_RST_EVACTIME;
      st_reg.sf_len <= `ICE_RST_SFLEN;
      st_reg.repeat_cfg <= `ICE_RST_REPEAT;
      st_reg.tx_allow <= 1'b1;
      st_reg.data_allow <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state flops, except scan_active, decoded from the state, and pslverr, which is tied low
  assign pready = st_reg.pready;
  assign prdata = st_reg.prdata;
  assign pslverr = 1'b0;
  assign data_allow = st_reg.data_allow;
  assign tx_allow = st_reg.tx_allow;
  assign elem_valid = st_reg.elem_valid;
  assign tx_elem = st_reg.elem;
  assign tune_req = st_reg.tune_req;
  assign tune_chan = st_reg.tune_chan;
  assign reuse_resv = st_reg.reuse_resv;
  assign join_req = st_reg.join_req;
  assign scan_active = (st_reg.state == ice_pkg::ICE_SCAN);
  assign irq = st_reg.irq;

endmodule

// >>> shared/ice_map.svh
`ifndef ICE_MAP_SVH
`define ICE_MAP_SVH
// Register byte offsets
`define ICE_OFF_CTRL 12'h000
`define ICE_OFF_STATUS 12'h004
`define ICE_OFF_MASK 12'h008
`define ICE_OFF_STATE 12'h00c
`define ICE_OFF_BACKUP 12'h010
`define ICE_OFF_COUNTDOWN 12'h014
`define ICE_OFF_AIRTIME 12'h018
`define ICE_OFF_EVACTIME 12'h01c
`define ICE_OFF_SFLEN 12'h020
`define ICE_OFF_ELEM 12'h024
// Control bit positions
`define ICE_CTRL_MASTER 0
`define ICE_CTRL_OWNER 1
`define ICE_CTRL_COPY 2
`define ICE_CTRL_REPEAT_LSB 8
// Status event bits
`define ICE_EV_DETECT 0
`define ICE_EV_VACATED 1
`define ICE_EV_SCAN 2
`define ICE_EV_AIRTIME 3
`define ICE_EV_JOIN 4
// Channel code meaning no channel is available
`define ICE_NO_CHANNEL 8'hff
// Reset values
`define ICE_RST_AIRTIME 32'h0000_2710
`define ICE_RST_EVACTIME 32'h0000_c350
`define ICE_RST_SFLEN 32'h0000_1000
`define ICE_RST_REPEAT 8'h04
`define ICE_NUM_EV 5
`endif

// >>> shared/ice_pkg.sv
package ice_pkg;
  typedef enum logic [6:0] {
    ICE_IDLE = 7'h01,
    ICE_ANNOUNCE = 7'h02,
    ICE_COUNT = 7'h04,
    ICE_AUTO = 7'h08,
    ICE_SCAN = 7'h10,
    ICE_JOIN = 7'h20,
    ICE_RESUME = 7'h40
  } ice_state_t;

  // Channel change element as carried in a beacon
  typedef struct packed {
    logic [7:0] target_channel;
    logic copy_flag;
    logic [31:0] countdown;
  } ice_elem_t;

  // APB request
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ice_apb_req_t;
endpackage
